// ==== core/host_port_select.sv ====
`timescale 1ns/1ps
`include "host_port_params.svh"
module host_port_select
  import host_port_pkg::*;
#(
  parameter int WAIT_CYCLES = `WAIT_LOW_CYCLES
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // strapping and strobe pins
  input wire logic LATCH_PIN,
  input wire logic ADDR_LINE_2,
  input wire logic ADDR_LINE_1,
  input wire logic ADDR_LINE_0_IN,
  input wire logic READ_PIN,
  input wire logic WRITE_PIN,
  input wire logic CHIP_SELECT_N,
  input wire logic GATE_ENABLE,
  // bus data input
  input wire logic [7:0] BUS_IN,
  // wait pin drive, enable low drives
  output logic ADDR_LINE_0_OUT,
  output logic ADDR_LINE_0_OE_N,
  // decoded results
  output bus_mode_t MODE,
  output logic MODE_VALID,
  output logic [5:0] REG_ADDR,
  output logic RD_STROBE,
  output logic WR_STROBE
);
  // ==============================
  // synchronised inputs
  logic [15:0] raw;
  logic [15:0] s;
  assign raw = {BUS_IN, GATE_ENABLE, CHIP_SELECT_N, WRITE_PIN, READ_PIN,
                ADDR_LINE_0_IN, ADDR_LINE_1, ADDR_LINE_2, LATCH_PIN};
  pin_sync #(.WIDTH(16)) u_sync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .d(raw),
    .q(s)
  );
  logic latch_s, addr2_s, addr1_s, addr0_s, rd_s, wr_s, cs_n_s, gate_s;
  logic [7:0] bus_s;
  assign {bus_s, gate_s, cs_n_s, wr_s, rd_s, addr0_s, addr1_s, addr2_s, latch_s} = s;

  // ==============================
  // mode detection
  logic [1:0] settle_reg;
  bus_mode_t mode_reg;
  logic valid_reg;

  // decode strapping into a bus style
  function automatic bus_mode_t decode_mode(input logic lat, input logic adr2, input logic adr1,
                                            input logic adr0, input logic rd, input logic wr);
    bus_mode_t m;
    m = MODE_SEP_DED;
    if (adr2 && adr1)
      m = MODE_HANDSHAKE;
    else if (!adr2 && adr1 && !lat)
      m = adr0 ? MODE_SEP_MUX : MODE_COM_MUX;
    else if (lat)
      m = (rd && !wr) ? MODE_COM_DED : MODE_SEP_DED;
    return m;
  endfunction

  // wait for synchroniser to fill, then capture once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      settle_reg <= 2'h0;
      mode_reg <= MODE_NONE;
      valid_reg <= 1'b0;
    end else if (CE) begin
      if (!valid_reg) begin
        if (settle_reg != 2'(`DETECT_DELAY))
          settle_reg <= settle_reg + 2'h1;
        else begin
          mode_reg <= decode_mode(latch_s, addr2_s, addr1_s, addr0_s, rd_s, wr_s);
          valid_reg <= 1'b1;
        end
      end
    end
  end
  assign MODE = mode_reg;
  assign MODE_VALID = valid_reg;

  logic hs;
  logic muxed;
  assign hs = valid_reg && mode_reg == MODE_HANDSHAKE;
  assign muxed = valid_reg && (mode_reg == MODE_SEP_MUX || mode_reg == MODE_COM_MUX);

  // ==============================
  // address strobe edge and wait enable
  logic astrb_d_reg;
  logic wait_armed_reg;
  logic astrb_fall;
  assign astrb_fall = astrb_d_reg && !latch_s;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      astrb_d_reg <= 1'b1;
      wait_armed_reg <= 1'b0;
    end else if (CE) begin
      astrb_d_reg <= latch_s;
      if (hs && astrb_fall)
        wait_armed_reg <= 1'b1;
    end
  end

  // ==============================
  // address capture
  logic [5:0] addr_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      addr_reg <= 6'h00;
    else if (CE) begin
      if (muxed && latch_s)
        addr_reg <= bus_s[5:0];
      else if (hs && !latch_s && !wr_s)
        addr_reg <= bus_s[5:0]; // address writes only, never a read cycle
      else if (valid_reg && !muxed && !hs)
        addr_reg <= {3'h0, addr2_s, addr1_s, addr0_s};
    end
  end
  assign REG_ADDR = addr_reg;

  // ==============================
  // data strobes
  logic dstrb;
  assign dstrb = !rd_s && !(gate_s && cs_n_s);
  always_comb begin
    RD_STROBE = 1'b0;
    WR_STROBE = 1'b0;
    if (valid_reg) begin
      unique case (mode_reg)
        MODE_SEP_DED, MODE_SEP_MUX: begin
          RD_STROBE = !cs_n_s && !rd_s;
          WR_STROBE = !cs_n_s && !wr_s;
        end
        MODE_COM_DED, MODE_COM_MUX: begin
          RD_STROBE = !cs_n_s && !rd_s && wr_s;
          WR_STROBE = !cs_n_s && !rd_s && !wr_s;
        end
        MODE_HANDSHAKE: begin
          RD_STROBE = dstrb && wr_s;
          WR_STROBE = dstrb && !wr_s;
        end
        default: begin
          RD_STROBE = 1'b0;
          WR_STROBE = 1'b0;
        end
      endcase
    end
  end

  // ==============================
  // wait handshake
  hs_state_t hs_reg;
  logic [7:0] wcnt_reg;
  logic wait_out_reg;
  logic strobe_any;
  assign strobe_any = hs && (dstrb || astrb_fall);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hs_reg <= HS_IDLE;
      wcnt_reg <= 8'h00;
      wait_out_reg <= 1'b1;
    end else if (CE) begin
      unique case (hs_reg)
        HS_IDLE: begin
          wait_out_reg <= 1'b1;
          // the arming strobe itself opens the first access cycle
          if (strobe_any && (wait_armed_reg || astrb_fall)) begin
            hs_reg <= HS_WAIT_LOW;
            wait_out_reg <= 1'b0;
            wcnt_reg <= 8'h00;
          end
        end
        HS_WAIT_LOW: begin
          wcnt_reg <= wcnt_reg + 8'h01;
          if (wcnt_reg == 8'(WAIT_CYCLES - 1)) begin
            wait_out_reg <= 1'b1;
            hs_reg <= HS_WAIT_HIGH;
          end
        end
        HS_WAIT_HIGH: begin
          if (rd_s && latch_s)
            hs_reg <= HS_IDLE;
        end
        default: begin
          hs_reg <= HS_IDLE;
        end
      endcase
    end
  end
  assign ADDR_LINE_0_OUT = wait_out_reg;
  assign ADDR_LINE_0_OE_N = !wait_armed_reg;

  // ==============================
  // checks
  a_wait_hiz_reset: assert property (@(posedge CLK) disable iff (RST)
    $fell(ADDR_LINE_0_OE_N) |-> ($past(hs) && $past(astrb_fall))) else $error("wait pin driven without strobe");
  a_mode_held: assert property (@(posedge CLK) disable iff (RST)
    valid_reg |=> (valid_reg && $stable(mode_reg))) else $error("mode changed after detect");
  a_wait_pulse: assert property (@(posedge CLK) disable iff (RST)
    (CE && hs_reg == HS_IDLE && strobe_any && (wait_armed_reg || astrb_fall)) |=> !ADDR_LINE_0_OUT)
    else $error("wait did not go low");
  a_hs_decode: assert property (@(posedge CLK) disable iff (RST)
    (CE && !valid_reg && settle_reg == 2'(`DETECT_DELAY) && addr2_s && addr1_s) |=> mode_reg == MODE_HANDSHAKE)
    else $error("handshake strap not decoded");
  a_gate_cs: assert property (@(posedge CLK) disable iff (RST)
    (hs && gate_s && cs_n_s) |-> !(RD_STROBE || WR_STROBE)) else $error("gated strobe passed");
  a_mux_latch: assert property (@(posedge CLK) disable iff (RST)
    (CE && muxed && latch_s) |=> REG_ADDR == $past(bus_s[5:0])) else $error("address not latched");
  a_reset_mode: assert property (@(posedge CLK) disable iff (RST)
    !valid_reg |-> (MODE == MODE_NONE)) else $error("mode set before detect");
  a_arm_hs_only: assert property (@(posedge CLK) disable iff (RST)
    wait_armed_reg |-> hs) else $error("wait armed outside handshake");
  a_no_addr_read: assert property (@(posedge CLK) disable iff (RST)
    (CE && hs && !latch_s && wr_s) |=> $stable(REG_ADDR)) else $error("address taken on read cycle");
endmodule

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for a vector of pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  // first stage read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ==== inc/host_port_params.svh ====
// Operation
// - Mux straps: latch low, address line 2 low, line 1 high; line 0 picks strobe style; both high handshake.
// - Handshake: read pin is data strobe, write pin is direction, latch pin address strobe.
// - Handshake: inactive chip select may suppress the data strobe.
// - Wait pin stays undriven after reset until first address strobe falling edge.
// - No handshake address read cycle; host only writes addresses.
// - Multiplexed buses capture six-bit address while latch high or address strobe low.
// - Handshake wait goes low to start access, high again after WAIT_LOW_CYCLES clocks.
// - After reset the mode is cleared, then detected from control pins.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define ADDR_WIDTH 6
`define DATA_WIDTH 8
`define WAIT_LOW_CYCLES 2
`define DETECT_DELAY 2
`endif

// ==== inc/host_port_pkg.sv ====
package host_port_pkg;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_SEP_DED, MODE_SEP_MUX, MODE_COM_DED, MODE_COM_MUX, MODE_HANDSHAKE
  } bus_mode_t;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT_LOW, HS_WAIT_HIGH} hs_state_t;
endpackage

// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
// ==========
// host side of the parallel port
module host_bus_model (
  // clock and wait pin from the device
  input wire logic clk,
  input wire logic wait_level,
  input wire logic wait_oe_n,
  // host driven pins
  output logic latch,
  output logic addr2,
  output logic addr1,
  output logic addr0_wire,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic [7:0] bus
);
  logic addr0_drv;
  // shared pin level, device wins while it drives
  assign addr0_wire = wait_oe_n ? addr0_drv : wait_level;
  // idle levels at time zero
  initial begin
    {latch, addr2, addr1, addr0_drv, rd_n, wr_n, cs_n} = 7'h7F;
    bus = 8'h00;
  end
  // pin order: latch, line 2, line 1, line 0, rd, wr, cs; handshake keeps cs low except in the gating test
  task automatic strap(input logic [6:0] pins);
    @(posedge clk);
    #2;
    {latch, addr2, addr1, addr0_drv, rd_n, wr_n, cs_n} = pins;
  endtask
  // address write only (write line low), held until wait goes high; done marks a finished cycle
  task automatic addr_write(input logic [7:0] adr, output logic done);
    logic low_seen;
    low_seen = 1'b0;
    done = 1'b0;
    @(posedge clk);
    #2;
    bus = adr;
    wr_n = 1'b0;
    latch = 1'b0;
    repeat (20) begin
      @(posedge clk);
      if (!wait_oe_n && !wait_level) low_seen = 1'b1;
      if (low_seen && wait_level) begin
        done = 1'b1;
        break;
      end
    end
    #2;
    latch = 1'b1;
    wr_n = 1'b1;
    bus = ~adr; // released bus shows no stale value
  endtask
endmodule

// ==== tb/parallel_host_port_type_select_tb_top.sv ====
`timescale 1ns/1ps
// ==========
// bench for interface type detection
module parallel_host_port_type_select_tb_top;
  import host_port_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gate_en = 1'b0;
  logic latch, addr2, addr1, addr0, rd_n, wr_n, cs_n, wait_level, wait_oe_n, rd_s, wr_s, valid;
  logic [7:0] bus;
  logic [5:0] reg_addr;
  bus_mode_t mode;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  host_bus_model u_host_bus_model (.clk(clk), .wait_level(wait_level), .wait_oe_n(wait_oe_n), .latch(latch),
    .addr2(addr2), .addr1(addr1), .addr0_wire(addr0), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .bus(bus));
  host_port_select u_host_port_select (.CLK(clk), .RST(rst), .CE(1'b1), .LATCH_PIN(latch), .ADDR_LINE_2(addr2),
    .ADDR_LINE_1(addr1), .ADDR_LINE_0_IN(addr0), .READ_PIN(rd_n), .WRITE_PIN(wr_n), .CHIP_SELECT_N(cs_n),
    .GATE_ENABLE(gate_en), .BUS_IN(bus), .ADDR_LINE_0_OUT(wait_level), .ADDR_LINE_0_OE_N(wait_oe_n), .MODE(mode),
    .MODE_VALID(valid), .REG_ADDR(reg_addr), .RD_STROBE(rd_s), .WR_STROBE(wr_s));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset with straps applied, then detection
  task automatic detect(input logic [6:0] pins, input bus_mode_t m);
    rst = 1'b1;
    u_host_bus_model.strap(pins);
    repeat (2) @(posedge clk);
    #2;
    check(mode, MODE_NONE);
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    check(valid, 1'b0);
    check(wait_oe_n, 1'b1);
    @(posedge clk);
    #2;
    check(valid, 1'b1);
    check(mode, m);
  endtask
  // every style, then straps moved after detection; dedicated straps keep line 2 low
  task automatic t_detect_all();
    logic [6:0] pins [5] = '{7'h1F, 7'h17, 7'h5F, 7'h5D, 7'h3E};
    bus_mode_t modes [5] = '{MODE_SEP_MUX, MODE_COM_MUX, MODE_SEP_DED, MODE_COM_DED, MODE_HANDSHAKE};
    for (int i = 0; i < 5; i++) begin
      detect(pins[i], modes[i]);
      u_host_bus_model.strap(pins[i] ^ 7'h70);
      repeat (6) @(posedge clk);
      #2;
      check(mode, modes[i]);
      check(wait_oe_n, 1'b1);
    end
  endtask
  // handshake address write and wait timing
  task automatic t_handshake();
    logic done;
    detect(7'h3E, MODE_HANDSHAKE);
    u_host_bus_model.strap(7'h7E);
    repeat (4) @(posedge clk);
    #2;
    check(wait_oe_n, 1'b1);
    fork
      u_host_bus_model.addr_write(8'hEA, done);
      begin
        repeat (4) @(posedge clk);
        #2;
        check(wait_oe_n, 1'b0);
        check(wait_level, 1'b0);
        repeat (2) @(posedge clk);
        #2;
        check(wait_level, 1'b1);
      end
    join
    check(done, 1'b1);
    check(reg_addr, 8'h2A);
  endtask
  // data strobe gating by chip select; chip select stays low while gating is off
  task automatic t_gate();
    logic [6:0] pins [3] = '{7'h7B, 7'h7A, 7'h78};
    logic [2:0] gate = 3'h3;
    logic [2:0] exp = 3'h2;
    logic [2:0] exp_wr = 3'h4;
    for (int i = 0; i < 3; i++) begin
      gate_en = gate[i];
      u_host_bus_model.strap(pins[i]);
      repeat (3) @(posedge clk);
      #2;
      check(rd_s, exp[i]);
      check(wr_s, exp_wr[i]);
    end
  endtask
  // dedicated address and separate strobes
  task automatic t_dedicated();
    detect(7'h5F, MODE_SEP_DED);
    u_host_bus_model.strap(7'h6A);
    repeat (3) @(posedge clk);
    #2;
    check(reg_addr, 8'h05);
    check({rd_s, wr_s}, 8'h02);
    u_host_bus_model.strap(7'h6C);
    repeat (3) @(posedge clk);
    #2;
    check({rd_s, wr_s}, 8'h01);
  endtask
  // main sequence
  initial begin
    t_detect_all();
    t_handshake();
    t_gate();
    t_dedicated();
    end_sim();
  end
endmodule
